// ---- clkctl_top.sv ----
// clkctl_top: clock-rate selection registers, tick generation and synthesizer control
// assumes: one oscillator clock, special-function register strobes synchronous to it,
// and an analog synthesizer whose lock level is synchronous to the oscillator clock
`include "clkctl_map.svh"

// Functional notes
// - speed bit clear: 12 periods per cycle
// - speed bit set: 6 periods per cycle
// - peripheral bits ignored while speed bit clear
// - speed set, peripheral bit clear: 6 periods
// - speed set, peripheral bit set: 12 periods
// - rate register A bit layout, bits 0-6
// - rate register B: serial bit 0, rest reserved
// - UART bit governs only modes 0 and 2
// - reserved bits read back as zero
// - rate and synth control reset to zero
// - synth divider resets to zero
// - synth control bit 1 enables synthesizer
// - lock bit follows synthesizer lock state while enabled, reads zero while disabled
// - synthesized clock feeds USB interface clock only once the synthesizer is enabled and locked
module clkctl_top
  import clkctl_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [7:0]  SFR_ADDR_I,
  input  wire logic        SFR_WR_I,
  input  wire logic        SFR_RD_I,
  input  wire logic [7:0]  SFR_WDATA_I,
  output logic [7:0]       SFR_RDATA_O,
  output logic             SFR_HIT_O,
  input  wire logic [1:0]  UART_MODE_I,
  input  wire logic        SYNTH_LOCKED_I,
  output logic             CPU_TICK_O,
  output logic             CPU_CYCLE_O,
  output logic [6:0]       PERIPH_TICK_O,
  output logic [6:0]       PERIPH_CYCLE_O,
  output logic             DOUBLE_SPEED_O,
  output logic             SYNTH_ENABLE_O,
  output logic [3:0]       SYNTH_FB_DIV_O,
  output logic [3:0]       SYNTH_REF_DIV_O,
  output logic             SYNTH_LOCK_LOST_O,
  output logic             USB_CLK_SELECT_O
);

  // stored register state
  clkctl_byte_t rate_a;
  clkctl_byte_t rate_b;
  logic         synth_enable;
  logic         synth_lock_flag;
  clkctl_byte_t synth_divider;
  clkctl_byte_t rdata;
  logic         lock_lost;
  logic         usb_select;

  clkctl_byte_t next_rate_a;
  clkctl_byte_t next_rate_b;
  logic         next_synth_enable;
  logic         next_synth_lock_flag;
  clkctl_byte_t next_synth_divider;
  clkctl_byte_t next_rdata;
  logic         next_lock_lost;
  logic         next_usb_select;

  // decoded fields
  logic         double_speed_select;
  logic         timer0_rate_select;
  logic         timer1_rate_select;
  logic         timer2_rate_select;
  logic         uart_rate_select;
  logic         counter_array_rate_select;
  logic         watchdog_rate_select;
  logic         serial_periph_rate_select;
  logic         uart_governed;
  logic [6:0]   periph_sel;
  logic         lock_visible;

  clkctl_rate_t cpu_rate;
  clkctl_rate_t periph_rate [`CLKCTL_PERIPH_COUNT];

  // decode of one special-function address
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == `CLKCTL_ADDR_RATE_A) ||
                (addr == `CLKCTL_ADDR_RATE_B) ||
                (addr == `CLKCTL_ADDR_SYNTH_CTRL) ||
                (addr == `CLKCTL_ADDR_SYNTH_DIV);
  endfunction : is_mapped

  // writable bits of each register; all others are reserved or read-only
  function automatic clkctl_byte_t wmask_of(input logic [7:0] addr);
    unique case (addr)
      `CLKCTL_ADDR_RATE_A: begin
        wmask_of = `CLKCTL_A_WMASK;
      end
      `CLKCTL_ADDR_RATE_B: begin
        wmask_of = `CLKCTL_B_WMASK;
      end
      `CLKCTL_ADDR_SYNTH_CTRL: begin
        wmask_of = `CLKCTL_S_WMASK;
      end
      `CLKCTL_ADDR_SYNTH_DIV: begin
        wmask_of = `CLKCTL_D_WMASK;
      end
      default: begin
        wmask_of = 8'h00;
      end
    endcase
  endfunction : wmask_of

  // rate of a peripheral from the global speed bit and its own bit
  function automatic clkctl_rate_t periph_rate_of(input logic speed, input logic own);
    if (!speed) begin
      periph_rate_of = CLKCTL_RATE_HALF;
    end else if (own) begin
      periph_rate_of = CLKCTL_RATE_HALF;
    end else begin
      periph_rate_of = CLKCTL_RATE_FULL;
    end
  endfunction : periph_rate_of

  // field extraction
  always_comb begin
    double_speed_select       = rate_a[`CLKCTL_A_DOUBLE_SPEED];
    timer0_rate_select        = rate_a[`CLKCTL_A_TIMER0];
    timer1_rate_select        = rate_a[`CLKCTL_A_TIMER1];
    timer2_rate_select        = rate_a[`CLKCTL_A_TIMER2];
    uart_rate_select          = rate_a[`CLKCTL_A_UART];
    counter_array_rate_select = rate_a[`CLKCTL_A_COUNTER_ARRAY];
    watchdog_rate_select      = rate_a[`CLKCTL_A_WATCHDOG];
    serial_periph_rate_select = rate_b[`CLKCTL_B_SERIAL_PERIPH];
    // the UART bit only steers the synchronous and fixed-rate modes
    uart_governed             = (UART_MODE_I == 2'd0) || (UART_MODE_I == 2'd2);
    periph_sel[CLKCTL_P_TIMER0]         = timer0_rate_select;
    periph_sel[CLKCTL_P_TIMER1]         = timer1_rate_select;
    periph_sel[CLKCTL_P_TIMER2]         = timer2_rate_select;
    periph_sel[CLKCTL_P_UART]           = uart_governed ? uart_rate_select : 1'b0;
    periph_sel[CLKCTL_P_COUNTER_ARRAY]  = counter_array_rate_select;
    periph_sel[CLKCTL_P_WATCHDOG]       = watchdog_rate_select;
    periph_sel[CLKCTL_P_SERIAL_PERIPH]  = serial_periph_rate_select;
  end

  // cadence selection
  // a rate change acts at once; the machine-cycle count is kept, so the cycle
  // in flight is stretched or shortened rather than restarted
  always_comb begin
    cpu_rate = double_speed_select ? CLKCTL_RATE_FULL : CLKCTL_RATE_HALF;
    for (int i = 0; i < `CLKCTL_PERIPH_COUNT; i++) begin
      periph_rate[i] = periph_rate_of(double_speed_select, periph_sel[i]);
    end
  end

  // register writes; reserved bits are masked off so they always read zero
  always_comb begin
    next_rate_a        = rate_a;
    next_rate_b        = rate_b;
    next_synth_enable  = synth_enable;
    next_synth_divider = synth_divider;
    if (SFR_WR_I) begin
      unique case (SFR_ADDR_I)
        `CLKCTL_ADDR_RATE_A: begin
          next_rate_a = SFR_WDATA_I & wmask_of(SFR_ADDR_I);
        end
        `CLKCTL_ADDR_RATE_B: begin
          next_rate_b = SFR_WDATA_I & wmask_of(SFR_ADDR_I);
        end
        `CLKCTL_ADDR_SYNTH_CTRL: begin
          // lock bit is not writable
          next_synth_enable = SFR_WDATA_I[`CLKCTL_S_ENABLE];
        end
        `CLKCTL_ADDR_SYNTH_DIV: begin
          // feedback field in the high nibble, reference field in the low nibble
          next_synth_divider = SFR_WDATA_I & wmask_of(SFR_ADDR_I);
        end
        default: begin
          next_rate_a = rate_a;
        end
      endcase
    end
  end

  // lock tracking: set while locked, cleared on loss or while disabled
  always_comb begin
    // a flag left from before a disable must not show once the enable is clear
    lock_visible         = synth_enable & synth_lock_flag;
    next_synth_lock_flag = synth_enable & SYNTH_LOCKED_I;
    next_lock_lost       = synth_lock_flag & ~next_synth_lock_flag;
    // the USB clock is taken from the synthesizer only once it is enabled and locked
    next_usb_select      = lock_visible;
  end

  // read path, registered; unmapped addresses read zero
  // a read together with a write returns the value held before the write
  always_comb begin
    next_rdata = rdata;
    if (SFR_RD_I) begin
      unique case (SFR_ADDR_I)
        `CLKCTL_ADDR_RATE_A: begin
          next_rdata = rate_a & wmask_of(SFR_ADDR_I);
        end
        `CLKCTL_ADDR_RATE_B: begin
          next_rdata = rate_b & wmask_of(SFR_ADDR_I);
        end
        `CLKCTL_ADDR_SYNTH_CTRL: begin
          next_rdata = 8'h00;
          next_rdata[`CLKCTL_S_ENABLE] = synth_enable;
          next_rdata[`CLKCTL_S_LOCK]   = lock_visible;
        end
        `CLKCTL_ADDR_SYNTH_DIV: begin
          next_rdata = synth_divider;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // register file
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      rate_a        <= `CLKCTL_RST_RATE_A;
      rate_b        <= `CLKCTL_RST_RATE_B;
      synth_enable  <= 1'(`CLKCTL_RST_SYNTH_CTRL >> `CLKCTL_S_ENABLE);
      synth_divider <= `CLKCTL_RST_SYNTH_DIV;
    end else begin
      rate_a        <= next_rate_a;
      rate_b        <= next_rate_b;
      synth_enable  <= next_synth_enable;
      synth_divider <= next_synth_divider;
    end
  end

  // lock tracking state
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      synth_lock_flag <= 1'b0;
      lock_lost       <= 1'b0;
      usb_select      <= 1'b0;
    end else begin
      synth_lock_flag <= next_synth_lock_flag;
      lock_lost       <= next_lock_lost;
      usb_select      <= next_usb_select;
    end
  end

  // read data register
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ticks are enables on the oscillator clock, so no derived clock domain is made
  // core tick: one per two oscillator periods in standard mode, every period when doubled
  clkctl_rate_gen u_cpu_rate (
    .clk_i   (MCLK_I),
    .rst_n_i (RST_N_I),
    .rate_i  (cpu_rate),
    .tick_o  (CPU_TICK_O),
    .cycle_o (CPU_CYCLE_O)
  );

  // one tick generator per peripheral
  for (genvar g = 0; g < `CLKCTL_PERIPH_COUNT; g++) begin : g_periph
    clkctl_rate_gen u_periph_rate (
      .clk_i   (MCLK_I),
      .rst_n_i (RST_N_I),
      .rate_i  (periph_rate[g]),
      .tick_o  (PERIPH_TICK_O[g]),
      .cycle_o (PERIPH_CYCLE_O[g])
    );
  end

  assign SFR_HIT_O         = is_mapped(SFR_ADDR_I) & (SFR_RD_I | SFR_WR_I);
  assign SFR_RDATA_O       = rdata;
  assign DOUBLE_SPEED_O    = double_speed_select;
  assign SYNTH_ENABLE_O    = synth_enable;
  assign SYNTH_FB_DIV_O    = synth_divider[`CLKCTL_D_FB_MSB:`CLKCTL_D_FB_LSB];
  assign SYNTH_REF_DIV_O   = synth_divider[`CLKCTL_D_REF_MSB:`CLKCTL_D_REF_LSB];
  assign SYNTH_LOCK_LOST_O = lock_lost;
  assign USB_CLK_SELECT_O  = usb_select;

endmodule : clkctl_top

// ---- clkctl_map.svh ----
// clkctl_map.svh: addresses, field positions, reset values and counts of the clock-rate block
// assumes: included by bare name wherever the register map is needed
`ifndef CLKCTL_MAP_SVH
`define CLKCTL_MAP_SVH

// special-function register addresses
`define CLKCTL_ADDR_RATE_A       8'h8f
`define CLKCTL_ADDR_SYNTH_CTRL   8'ha3
`define CLKCTL_ADDR_SYNTH_DIV    8'ha4
`define CLKCTL_ADDR_RATE_B       8'haf

// clock_rate_control_a fields
`define CLKCTL_A_DOUBLE_SPEED    0
`define CLKCTL_A_TIMER0          1
`define CLKCTL_A_TIMER1          2
`define CLKCTL_A_TIMER2          3
`define CLKCTL_A_UART            4
`define CLKCTL_A_COUNTER_ARRAY   5
`define CLKCTL_A_WATCHDOG        6
`define CLKCTL_A_WMASK           8'h7f

// clock_rate_control_b fields
`define CLKCTL_B_SERIAL_PERIPH   0
`define CLKCTL_B_WMASK           8'h01

// synth_control fields
`define CLKCTL_S_LOCK            0
`define CLKCTL_S_ENABLE          1
`define CLKCTL_S_WMASK           8'h02

// synth_divider fields
`define CLKCTL_D_FB_MSB          7
`define CLKCTL_D_FB_LSB          4
`define CLKCTL_D_REF_MSB         3
`define CLKCTL_D_REF_LSB         0
`define CLKCTL_D_WMASK           8'hff

// reset values
`define CLKCTL_RST_RATE_A        8'h00
`define CLKCTL_RST_RATE_B        8'h00
`define CLKCTL_RST_SYNTH_CTRL    8'h00
`define CLKCTL_RST_SYNTH_DIV     8'h00

// timing: oscillator periods per machine cycle, ticks per machine cycle and peripheral count
`define CLKCTL_OSC_PER_CYCLE_STD 12
`define CLKCTL_OSC_PER_CYCLE_X2  6
`define CLKCTL_TICKS_PER_CYCLE   3'd6
`define CLKCTL_PERIPH_COUNT      7

`endif

// ---- clkctl_pkg.sv ----
// clkctl_pkg: types shared by the clock-rate block
// assumes: compiled before every module of the block
package clkctl_pkg;

  typedef logic [7:0] clkctl_byte_t;

  // index of each peripheral in the tick vectors
  typedef enum logic [2:0] {
    CLKCTL_P_TIMER0,
    CLKCTL_P_TIMER1,
    CLKCTL_P_TIMER2,
    CLKCTL_P_UART,
    CLKCTL_P_COUNTER_ARRAY,
    CLKCTL_P_WATCHDOG,
    CLKCTL_P_SERIAL_PERIPH
  } clkctl_periph_t;

  // tick cadence of one clock user
  typedef enum logic {
    CLKCTL_RATE_FULL,
    CLKCTL_RATE_HALF
  } clkctl_rate_t;

endpackage : clkctl_pkg

// ---- clkctl_rate_gen.sv ----
// clkctl_rate_gen: tick and machine-cycle strobes for one clock user
// assumes: clk_i is the oscillator clock; rate_i may change at any cycle
`include "clkctl_map.svh"

module clkctl_rate_gen
  import clkctl_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire clkctl_rate_t rate_i,
  output logic              tick_o,
  output logic              cycle_o
);

  logic       half_phase;
  logic [2:0] tick_cnt;
  logic       next_half_phase;
  logic [2:0] next_tick_cnt;
  logic       next_tick;
  logic       next_cycle;
  logic       fire;

  // half rate fires every second oscillator period, full rate every period
  always_comb begin
    fire            = (rate_i == CLKCTL_RATE_FULL) || half_phase;
    next_half_phase = (rate_i == CLKCTL_RATE_HALF) ? ~half_phase : 1'b0;
    next_tick       = fire;
    next_tick_cnt   = tick_cnt;
    next_cycle      = 1'b0;
    if (fire) begin
      if (tick_cnt == `CLKCTL_TICKS_PER_CYCLE - 3'd1) begin
        next_tick_cnt = 3'd0;
        next_cycle    = 1'b1;
      end else begin
        next_tick_cnt = tick_cnt + 3'd1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      half_phase <= 1'b0;
      tick_cnt   <= 3'd0;
      tick_o     <= 1'b0;
      cycle_o    <= 1'b0;
    end else begin
      half_phase <= next_half_phase;
      tick_cnt   <= next_tick_cnt;
      tick_o     <= next_tick;
      cycle_o    <= next_cycle;
    end
  end

endmodule : clkctl_rate_gen

// ---- clkctl_top_properties.sv ----
// checker: port-level properties of clkctl_top
// assumes: bound to clkctl_top, one clock MCLK_I, synchronous active-low reset
module clkctl_top_properties (
  input wire logic       MCLK_I,
  input wire logic       RST_N_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic       SFR_WR_I,
  input wire logic       SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic       SFR_HIT_O,
  input wire logic       SYNTH_LOCKED_I,
  input wire logic       CPU_TICK_O,
  input wire logic       CPU_CYCLE_O,
  input wire logic [6:0] PERIPH_TICK_O,
  input wire logic [6:0] PERIPH_CYCLE_O,
  input wire logic       DOUBLE_SPEED_O,
  input wire logic       SYNTH_ENABLE_O,
  input wire logic [3:0] SYNTH_FB_DIV_O,
  input wire logic [3:0] SYNTH_REF_DIV_O,
  input wire logic       SYNTH_LOCK_LOST_O,
  input wire logic       USB_CLK_SELECT_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);

  wire ds = DOUBLE_SPEED_O;

  AST_STD_TICK: assert property (!ds && !$past(ds) && CPU_TICK_O |=> !CPU_TICK_O ##1 (CPU_TICK_O || ds))
    else $error("cpu tick cadence wrong in standard mode");
  AST_X2_TICK: assert property (ds && $past(ds) && $past(ds, 2) |-> CPU_TICK_O)
    else $error("cpu tick missing in double speed");
  AST_CYCLE_ON_TICK: assert property ((PERIPH_CYCLE_O & ~PERIPH_TICK_O) == 7'h00 && (!CPU_CYCLE_O || CPU_TICK_O))
    else $error("cycle pulse without tick");
  AST_PERIPH_STD: assert property (!ds && !$past(ds) && !$past(ds, 2) |-> (PERIPH_TICK_O & $past(PERIPH_TICK_O)) == 7'h00)
    else $error("peripheral tick too fast in standard mode");
  AST_HIT: assert property (SFR_HIT_O == ((SFR_RD_I || SFR_WR_I) && SFR_ADDR_I inside {8'h8f, 8'haf, 8'ha3, 8'ha4}))
    else $error("address decode wrong");
  AST_WR_SPEED: assert property (SFR_WR_I && SFR_ADDR_I == 8'h8f |=> ds == $past(SFR_WDATA_I[0]))
    else $error("speed bit not written");
  AST_WR_ENABLE: assert property (SFR_WR_I && SFR_ADDR_I == 8'ha3 |=> SYNTH_ENABLE_O == $past(SFR_WDATA_I[1]))
    else $error("synth enable not written");
  AST_WR_DIV: assert property (SFR_WR_I && SFR_ADDR_I == 8'ha4 |=> {SYNTH_FB_DIV_O, SYNTH_REF_DIV_O} == $past(SFR_WDATA_I))
    else $error("divider fields wrong");
  AST_RD_CTRL: assert property (SFR_RD_I && !SFR_WR_I && SFR_ADDR_I == 8'ha3 |=>
    SFR_RDATA_O == {6'h00, $past(SYNTH_ENABLE_O), USB_CLK_SELECT_O})
    else $error("synth control read wrong");
  AST_USB_SEL: assert property (SYNTH_ENABLE_O && SYNTH_LOCKED_I ##1 SYNTH_ENABLE_O |-> ##1 USB_CLK_SELECT_O)
    else $error("lock not followed");
  AST_USB_CAUSE: assert property (USB_CLK_SELECT_O |-> $past(SYNTH_ENABLE_O, 2))
    else $error("usb select while disabled");
  AST_LOST: assert property ($fell(USB_CLK_SELECT_O) |-> SYNTH_LOCK_LOST_O || $past(SYNTH_LOCK_LOST_O))
    else $error("lock loss not flagged");

  cover property (SFR_WR_I && SFR_ADDR_I == 8'h8f ##1 ds);
  cover property ($rose(USB_CLK_SELECT_O));
  cover property (SYNTH_LOCK_LOST_O);
endmodule : clkctl_top_properties

// ---- clkctl_top_tb.sv ----
// clkctl_top_tb: self-checking bench for clkctl_top
// assumes: clkctl_pkg, clkctl_top and the property checker compiled first
module clkctl_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [1:0]  umode = 2'h0;
  logic        locked = 1'b0;
  logic [7:0]  rdata, fr;
  logic [6:0]  ptick, pcyc;
  logic        hit, ctick, ccyc, dspd, sen, lost, usb;
  logic [3:0]  fb, rf;
  logic [31:0] seed = 32'hee49;
  logic [7:0]  g;
  int          error_cnt = 0;
  int          checked = 0;
  int          cyc = 0;

  clkctl_top dut (.MCLK_I(mclk), .RST_N_I(rst_n), .SFR_ADDR_I(addr), .SFR_WR_I(wr), .SFR_RD_I(rd),
    .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata), .SFR_HIT_O(hit), .UART_MODE_I(umode),
    .SYNTH_LOCKED_I(locked), .CPU_TICK_O(ctick), .CPU_CYCLE_O(ccyc), .PERIPH_TICK_O(ptick),
    .PERIPH_CYCLE_O(pcyc), .DOUBLE_SPEED_O(dspd), .SYNTH_ENABLE_O(sen), .SYNTH_FB_DIV_O(fb),
    .SYNTH_REF_DIV_O(rf), .SYNTH_LOCK_LOST_O(lost), .USB_CLK_SELECT_O(usb));

  always #50 mclk = ~mclk;

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction : lfsr

  // index 0..6 peripherals, 7 cpu; returns 1 for half rate
  function automatic logic half(int i, logic [7:0] a, logic b0, logic [1:0] m);
    if (!a[0]) return 1'b1;
    if (i == 7 || (i == 3 && m[0])) return 1'b0;
    return (i == 6) ? b0 : a[i+1];
  endfunction : half

  task automatic results();
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic chk(string nm, logic [7:0] e, logic [7:0] v);
    checked++;
    if (v !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, v);
    end
  endtask : chk

  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    d = rdata;
  endtask : rd_reg

  task automatic rd_zero();
    logic [7:0] ad [4] = '{8'h8f, 8'haf, 8'ha3, 8'ha4};
    for (int k = 0; k < 4; k++) begin
      rd_reg(ad[k], g);
      chk("reset_value", 8'h00, g);
    end
  endtask : rd_zero

  // raw=1 writes ones into reserved bits on purpose; fifth entry is unmapped
  task automatic regs(logic [7:0] d, logic raw);
    logic [7:0] ad [5] = '{8'h8f, 8'haf, 8'ha3, 8'ha4, 8'h90};
    logic [7:0] rm [5] = '{8'h7f, 8'h01, 8'h02, 8'hff, 8'h00};
    for (int k = 0; k < 5; k++) begin
      wr_reg(ad[k], raw ? d : (d & rm[k]));
      rd_reg(ad[k], g);
      chk("reg_read", d & rm[k], g);
    end
  endtask : regs

  task automatic rates(logic [7:0] a, logic [7:0] b, logic [1:0] m);
    logic [7:0] nt [8];
    logic [7:0] nc [8];
    logic [7:0] t8, c8;
    logic       h;
    wr_reg(8'h8f, a);
    wr_reg(8'haf, b);
    umode = m;
    for (int i = 0; i < 8; i++) begin
      nt[i] = 8'h00;
      nc[i] = 8'h00;
    end
    repeat (4) @(negedge mclk);
    repeat (24) begin
      @(negedge mclk);
      t8 = {ctick, ptick};
      c8 = {ccyc, pcyc};
      for (int i = 0; i < 8; i++) begin
        nt[i] += {7'h00, t8[i]};
        nc[i] += {7'h00, c8[i]};
      end
    end
    for (int i = 0; i < 8; i++) begin
      h = half(i, a, b[0], m);
      chk("ticks", h ? 8'h0c : 8'h18, nt[i]);
      chk("cycles", h ? 8'h02 : 8'h04, nc[i]);
    end
    chk("double_speed", {7'h00, a[0]}, {7'h00, dspd});
  endtask : rates

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    rd_zero();
    regs(8'hff, 1'b1);
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      regs(seed[7:0], 1'b0);
    end
    rates(8'h7e, 8'h01, 2'h0);
    rates(8'h01, 8'h00, 2'h0);
    rates(8'h7f, 8'h01, 2'h2);
    for (int m = 0; m < 4; m++) begin
      rates(8'h11, 8'h00, m[1:0]);
    end
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      rates(seed[7:0] & 8'h7f, {7'h00, seed[8]}, seed[10:9]);
    end
    wr_reg(8'ha4, 8'h30);
    chk("div_fields", 8'h30, {fb, rf});
    locked = 1'b1;
    wr_reg(8'ha3, 8'h01);
    rd_reg(8'ha3, g);
    chk("lock_disabled", 8'h00, g);
    wr_reg(8'ha3, 8'h02);
    chk("synth_enable", 8'h01, {7'h00, sen});
    rd_reg(8'ha3, g);
    while (!g[0]) begin
      rd_reg(8'ha3, g);
    end
    chk("lock_set", 8'h03, g);
    chk("usb_select", 8'h01, {7'h00, usb});
    locked = 1'b0;
    fr = 8'h00;
    repeat (4) begin
      @(negedge mclk);
      fr += {7'h00, lost};
    end
    chk("lost_pulses", 8'h01, fr);
    rd_reg(8'ha3, g);
    chk("lock_clear", 8'h02, g);
    rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    rd_zero();
    results();
  end
endmodule : clkctl_top_tb

bind clkctl_top clkctl_top_properties u_props (.*);
